// ===== design/kr_train_pkg.sv
// shared register map, field layouts and event numbering
package kr_train_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_STARTUP_STATUS = 16'h9020;
	localparam logic [15:0] IDX_PARTNER_REQ = 16'h9098;
	localparam logic [15:0] IDX_PARTNER_STAT = 16'h9099;
	localparam logic [15:0] IDX_LOCAL_REQ = 16'h909A;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h9100;
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'h9101;
	localparam logic [15:0] IDX_IRQ_CLEAR = 16'h9102;

	// register width, reset value and address span
	localparam int REG_W = 16;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int MIN_ADDR_W = 18;
	localparam int MAX_ADDR_W = 32;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// update request codes
	localparam logic [1:0] UPD_HOLD = 2'h0;
	localparam logic [1:0] UPD_INC = 2'h1;
	localparam logic [1:0] UPD_DEC = 2'h2;
	localparam logic [1:0] UPD_RSVD = 2'h3;

	// coefficient state codes
	localparam logic [1:0] CST_NOT_UPDATED = 2'h0;
	localparam logic [1:0] CST_UPDATED = 2'h1;
	localparam logic [1:0] CST_MINIMUM = 2'h2;
	localparam logic [1:0] CST_MAXIMUM = 2'h3;

	// interrupt event bit positions
	localparam int EV_COUNT = 5;
	localparam int EV_STARTUP_DONE = 0;
	localparam int EV_PARTNER_READY = 1;
	localparam int EV_PARTNER_REQ = 2;
	localparam int EV_PARTNER_STAT = 3;
	localparam int EV_LOCAL_REQ = 4;

	// five two-bit fields, swing in 9:8 down to k(-1) in 1:0
	typedef struct packed {
		logic [1:0] swing;
		logic [1:0] post2;
		logic [1:0] kplus;
		logic [1:0] kmain;
		logic [1:0] kminus;
	} coeff_fields_t;

	// request word: flags in 13:12, updates in 9:0
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic preset_req;
		logic init_req;
		logic [1:0] rsvd_mid;
		coeff_fields_t upd;
	} coeff_req_word_t;

	// partner status word: ready in 15, states in 9:0
	typedef struct packed {
		logic receiver_ready;
		logic [4:0] rsvd;
		coeff_fields_t state;
	} coeff_stat_word_t;

	// everything software can see of training
	typedef struct packed {
		logic startup_in_progress;
		coeff_req_word_t partner_req;
		coeff_stat_word_t partner_stat;
		coeff_req_word_t local_req;
	} training_view_t;

endpackage

// ===== design/kr_train_capture.sv
`timescale 1ns/1ps
`default_nettype none
// registers the training engine's words and flags changes as pulses
module kr_train_capture (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic startup_in_progress, // training start-up running
	input wire kr_train_pkg::coeff_req_word_t partner_req_in, // from partner
	input wire kr_train_pkg::coeff_stat_word_t partner_stat_in, // from partner
	input wire kr_train_pkg::coeff_req_word_t local_req_in, // to partner
	output var kr_train_pkg::training_view_t view, // registered view
	output var logic [kr_train_pkg::EV_COUNT-1:0] events // one-cycle pulses
);

	// whole module state
	typedef struct packed {
		kr_train_pkg::training_view_t view;
		logic [kr_train_pkg::EV_COUNT-1:0] events;
	} cap_state_t;

	cap_state_t st_ff; // registered state
	cap_state_t nxt_st; // next state

	// sample inputs, force reserved bits low, detect edges and changes
	always_comb begin
		nxt_st = st_ff;
		nxt_st.view.startup_in_progress = startup_in_progress;
		nxt_st.view.partner_req = partner_req_in;
		nxt_st.view.partner_req.rsvd_hi = '0;
		nxt_st.view.partner_req.rsvd_mid = '0;
		nxt_st.view.partner_stat = partner_stat_in;
		nxt_st.view.partner_stat.rsvd = '0;
		nxt_st.view.local_req = local_req_in;
		nxt_st.view.local_req.rsvd_hi = '0;
		nxt_st.view.local_req.rsvd_mid = '0;
		// start-up finished: falling edge of the progress flag
		nxt_st.events[kr_train_pkg::EV_STARTUP_DONE] =
			st_ff.view.startup_in_progress && !startup_in_progress;
		// far receiver declared itself ready
		nxt_st.events[kr_train_pkg::EV_PARTNER_READY] =
			!st_ff.view.partner_stat.receiver_ready &&
			partner_stat_in.receiver_ready;
		// any visible change of a word raises its event
		nxt_st.events[kr_train_pkg::EV_PARTNER_REQ] =
			nxt_st.view.partner_req != st_ff.view.partner_req;
		nxt_st.events[kr_train_pkg::EV_PARTNER_STAT] =
			nxt_st.view.partner_stat != st_ff.view.partner_stat;
		nxt_st.events[kr_train_pkg::EV_LOCAL_REQ] =
			nxt_st.view.local_req != st_ff.view.local_req;
	end

	// state register; everything clears to zero on reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign view = st_ff.view;
	assign events = st_ff.events;

endmodule
`default_nettype wire

// ===== design/kr_link_training_status.sv
// Functional notes
// - start-up status bit 0 high while training runs
// - partner preset bit 13, initialize bit 12
// - partner five two-bit update requests in 9:0
// - partner receiver ready shown at bit 15
// - partner five coefficient states in 9:0
// - local preset 13, initialize 12, 15:14 reserved
// - local five update requests, reset to hold
// - training registers read-only, reset to zero
`timescale 1ns/1ps
`default_nettype none
module kr_link_training_status #(
	parameter int ADDR_W = 18 // axi address width
) (
	input wire logic clk_sys, // system clock, 20 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic startup_in_progress, // training start-up running
	input wire kr_train_pkg::coeff_req_word_t partner_req_in, // partner asks
	input wire kr_train_pkg::coeff_stat_word_t partner_stat_in, // partner says
	input wire kr_train_pkg::coeff_req_word_t local_req_in, // we ask
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic irq // level, high while an enabled event is pending
);

	localparam int EVN = kr_train_pkg::EV_COUNT;
	localparam int RW = kr_train_pkg::REG_W;

	// refuse address widths that cannot reach the map or exceed axi
	generate
		if (ADDR_W < kr_train_pkg::MIN_ADDR_W ||
			ADDR_W > kr_train_pkg::MAX_ADDR_W) begin : g_bad_addr_w
			$error("ADDR_W out of range for the register map");
		end
	endgenerate

	// whole slave state: channel holds, responses, interrupt regs
	typedef struct packed {
		logic aw_held; // write address captured
		logic [ADDR_W-1:0] aw_addr;
		logic w_held; // write data captured
		logic [RW-1:0] w_data;
		logic [1:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [RW-1:0] r_data;
		logic [1:0] r_resp;
		logic [EVN-1:0] irq_status; // sticky events
		logic [EVN-1:0] irq_enable; // event mask
	} slv_state_t;

	slv_state_t st_ff; // registered state
	slv_state_t nxt_st; // next state

	kr_train_pkg::training_view_t view; // captured training words
	logic [EVN-1:0] events; // one-cycle event pulses
	logic [EVN-1:0] clr; // clear mask of this cycle
	logic [RW-1:0] rd_data; // read mux result
	logic [1:0] rd_resp; // read decode answer
	logic [1:0] wr_resp; // write decode answer

	// capture of training words and event detection
	kr_train_capture u_capture (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.startup_in_progress(startup_in_progress),
		.partner_req_in(partner_req_in),
		.partner_stat_in(partner_stat_in),
		.local_req_in(local_req_in),
		.view(view),
		.events(events)
	);

	// word index match; low two address bits are ignored
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] idx);
		hit = a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
	endfunction

	// read-only words, the training words and the event status: software can only look
	function automatic logic ro_hit(input logic [ADDR_W-1:0] a);
		ro_hit = hit(a, kr_train_pkg::IDX_STARTUP_STATUS) ||
			hit(a, kr_train_pkg::IDX_PARTNER_REQ) ||
			hit(a, kr_train_pkg::IDX_PARTNER_STAT) ||
			hit(a, kr_train_pkg::IDX_LOCAL_REQ) ||
			hit(a, kr_train_pkg::IDX_IRQ_STATUS);
	endfunction

	// bus channels, register writes, sticky events and read mux
	always_comb begin
		nxt_st = st_ff;
		clr = '0;
		rd_data = kr_train_pkg::REG_RESET;
		rd_resp = kr_train_pkg::RESP_OKAY;
		wr_resp = kr_train_pkg::RESP_OKAY;
		// address and data are taken independently, in either order
		if (s_axi_awvalid && !st_ff.aw_held) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_held) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = s_axi_wdata[RW-1:0];
			nxt_st.w_strb = s_axi_wstrb[1:0];
		end
		// response leaves once the master takes it
		if (st_ff.b_valid && s_axi_bready) begin
			nxt_st.b_valid = 1'b0;
		end
		// commit once both halves are in and no response is pending
		if (st_ff.aw_held && st_ff.w_held && !st_ff.b_valid) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held = 1'b0;
			nxt_st.b_valid = 1'b1;
			if (hit(st_ff.aw_addr, kr_train_pkg::IDX_IRQ_ENABLE)) begin
				if (st_ff.w_strb[0]) begin
					nxt_st.irq_enable = st_ff.w_data[EVN-1:0];
				end
			end else if (hit(st_ff.aw_addr, kr_train_pkg::IDX_IRQ_CLEAR)) begin
				if (st_ff.w_strb[0]) begin
					clr = st_ff.w_data[EVN-1:0];
				end
			end else if (ro_hit(st_ff.aw_addr)) begin
				// read-only word: accepted, nothing changes
				wr_resp = kr_train_pkg::RESP_OKAY;
			end else begin
				// nothing lives here
				wr_resp = kr_train_pkg::RESP_SLVERR;
			end
			nxt_st.b_resp = wr_resp;
		end
		// a new event beats a clear landing in the same cycle
		nxt_st.irq_status = (st_ff.irq_status & ~clr) | events;
		// read data leaves once the master takes it
		if (st_ff.r_valid && s_axi_rready) begin
			nxt_st.r_valid = 1'b0;
		end
		// one read in flight; the word is frozen at address time
		if (s_axi_arvalid && !st_ff.r_valid) begin
			if (hit(s_axi_araddr, kr_train_pkg::IDX_STARTUP_STATUS)) begin
				rd_data = RW'(view.startup_in_progress);
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_REQ)) begin
				rd_data = view.partner_req;
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_STAT)) begin
				rd_data = view.partner_stat;
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_LOCAL_REQ)) begin
				rd_data = view.local_req;
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_IRQ_STATUS)) begin
				rd_data = RW'(st_ff.irq_status);
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_IRQ_ENABLE)) begin
				rd_data = RW'(st_ff.irq_enable);
			end else if (hit(s_axi_araddr, kr_train_pkg::IDX_IRQ_CLEAR)) begin
				// write-only, reads as zero
				rd_data = kr_train_pkg::REG_RESET;
			end else begin
				rd_resp = kr_train_pkg::RESP_SLVERR;
			end
			nxt_st.r_valid = 1'b1;
			nxt_st.r_data = rd_data;
			nxt_st.r_resp = rd_resp;
		end
	end

	// state register; interrupt regs and responses clear on reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ready terms follow the holds, so no combinational path from valid
	assign s_axi_awready = !st_ff.aw_held;
	assign s_axi_wready = !st_ff.w_held;
	assign s_axi_bvalid = st_ff.b_valid;
	assign s_axi_bresp = st_ff.b_resp;
	assign s_axi_arready = !st_ff.r_valid;
	assign s_axi_rvalid = st_ff.r_valid;
	assign s_axi_rresp = st_ff.r_resp;
	// upper half of every word reads as zero
	assign s_axi_rdata = {16'h0000, st_ff.r_data};
	assign irq = |(st_ff.irq_status & st_ff.irq_enable);

	// read address accepted this cycle
	logic ar_fire;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	a_startup_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_STARTUP_STATUS) |=>
		s_axi_rvalid && s_axi_rdata[0] == $past(view.startup_in_progress) &&
		s_axi_rdata[15:1] == 15'h0000)
		else $error("start-up bit does not track training progress");

	a_partner_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_REQ) |=>
		s_axi_rdata[13] == $past(partner_req_in.preset_req, 2) &&
		s_axi_rdata[12] == $past(partner_req_in.init_req, 2))
		else $error("partner preset or initialize flag wrong");

	a_partner_updates: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_REQ) |=>
		s_axi_rdata[9:0] == $past(partner_req_in.upd, 2) &&
		s_axi_rdata[11:10] == 2'h0)
		else $error("partner update requests wrong");

	a_partner_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_STAT) ##1
		s_axi_rvalid |->
		s_axi_rdata[15] == $past(partner_stat_in.receiver_ready, 2))
		else $error("partner receiver ready bit wrong");

	a_partner_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_PARTNER_STAT) |=>
		s_axi_rdata[9:0] == $past(partner_stat_in.state, 2) &&
		s_axi_rdata[14:10] == 5'h00)
		else $error("partner coefficient states wrong");

	a_local_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_LOCAL_REQ) |=>
		s_axi_rdata[13:12] == {$past(local_req_in.preset_req, 2),
		$past(local_req_in.init_req, 2)} && s_axi_rdata[15:14] == 2'h0)
		else $error("local flags or reserved bits wrong");

	a_local_updates: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ar_fire && hit(s_axi_araddr, kr_train_pkg::IDX_LOCAL_REQ) |=>
		s_axi_rdata[9:0] == $past(local_req_in.upd, 2))
		else $error("local update requests wrong");

	a_ro_write_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_ff.aw_held && st_ff.w_held && !st_ff.b_valid &&
		ro_hit(st_ff.aw_addr) |=> s_axi_bvalid &&
		s_axi_bresp == kr_train_pkg::RESP_OKAY &&
		$stable(st_ff.irq_enable))
		else $error("write to a read-only word had an effect");

	a_event_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(events & st_ff.irq_enable) != '0 && $stable(st_ff.irq_enable) |=>
		irq)
		else $error("enabled event did not raise the interrupt");

endmodule
`default_nettype wire

// ===== tb/kr_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-end training engine: presents its request and status words and
// changes them only when the bench commands a new pair or reset clears them
module kr_partner_model (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic load, // take the commanded words
	input wire logic [15:0] req_cmd, // next request word
	input wire logic [15:0] stat_cmd, // next status word
	output var kr_train_pkg::coeff_req_word_t req_out, // request to device
	output var kr_train_pkg::coeff_stat_word_t stat_out // status to device
);
	// words hold between updates, as a frame field would
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_out <= '0; // hold everywhere, no flags
			stat_out <= '0; // not ready, nothing updated
		end else if (load) begin
			req_out <= req_cmd;
			stat_out <= stat_cmd;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_kr_link_training_status.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
	error_cnt++; $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end
module tb_kr_link_training_status;
	localparam int ADDR_W = 18; // smallest legal span
	logic clk_sys = 1'b0; // 20 MHz
	logic rst_n = 1'b0; // held low at start
	logic startup_in_progress = 1'b0; // training running
	kr_train_pkg::coeff_req_word_t local_req = '0; // our requests
	kr_train_pkg::coeff_req_word_t partner_req; // from partner model
	kr_train_pkg::coeff_stat_word_t partner_stat; // from partner model
	logic p_load = 1'b0; // partner update strobe
	logic [15:0] p_req = '0; // next partner request
	logic [15:0] p_stat = '0; // next partner status
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0; // bus addresses
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0; // write data
	logic [3:0] wstrb = '0; // byte enables
	logic awready, wready, bvalid, arready, rvalid, irq; // design outputs
	logic [1:0] bresp, rresp; // responses
	logic [31:0] rdata, rd; // read data, last read
	logic [1:0] rs; // last response
	int error_cnt = 0, check_count = 0;
	// rows: start-up flag, partner request, partner status, local request;
	// reserved bits are set in the third row to show they read back 0
	logic [48:0] rows [5] = '{
		{1'b1, 16'h2155, 16'h8155, 16'h1155},
		{1'b0, 16'h12AA, 16'h02AA, 16'h22AA},
		{1'b1, 16'hFFFF, 16'hFFFF, 16'hFFFF},
		{1'b0, 16'h0000, 16'h0000, 16'h0000},
		{1'b0, 16'h30E4, 16'h00E4, 16'h01B1}};
	logic [15:0] view_idx [4] = '{kr_train_pkg::IDX_STARTUP_STATUS,
		kr_train_pkg::IDX_PARTNER_REQ, kr_train_pkg::IDX_PARTNER_STAT,
		kr_train_pkg::IDX_LOCAL_REQ};

	always #25 clk_sys = ~clk_sys;

	kr_partner_model partner (.clk_sys(clk_sys), .rst_n(rst_n),
		.load(p_load), .req_cmd(p_req), .stat_cmd(p_stat),
		.req_out(partner_req), .stat_out(partner_stat));

	kr_link_training_status #(.ADDR_W(ADDR_W)) DUT (.clk_sys(clk_sys),
		.rst_n(rst_n), .startup_in_progress(startup_in_progress),
		.partner_req_in(partner_req), .partner_stat_in(partner_stat),
		.local_req_in(local_req), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));

	// each half is released at the edge that takes it; only the
	// watchdog ends a wait, so a dead slave shows as a timeout
	task automatic bus_wr(input logic [15:0] idx, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= ADDR_W'({idx, 2'b00});
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic bus_rd(input logic [15:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= ADDR_W'({idx, 2'b00});
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// irq is looked at once the edge's updates have landed
	task automatic irq_is(input logic exp);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("irq", exp, irq)
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// watchdog: the whole run needs under two hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish;
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (view_idx[i]) begin
			bus_rd(view_idx[i], rd, rs);
			`CHK("reset view", 32'h0, rd)
		end
		// ordinary cases: drive words, read every view back
		foreach (rows[i]) begin
			@(posedge clk_sys);
			startup_in_progress <= rows[i][48];
			p_req <= rows[i][47:32];
			p_stat <= rows[i][31:16];
			local_req <= rows[i][15:0];
			p_load <= 1'b1;
			@(posedge clk_sys);
			p_load <= 1'b0;
			repeat (3) @(posedge clk_sys);
			bus_rd(view_idx[0], rd, rs);
			`CHK("startup", {31'h0, rows[i][48]}, rd)
			bus_rd(view_idx[1], rd, rs);
			`CHK("p req", {16'h0, rows[i][47:32] & 16'h33FF}, rd)
			bus_rd(view_idx[2], rd, rs);
			`CHK("p stat", {16'h0, rows[i][31:16] & 16'h83FF}, rd)
			bus_rd(view_idx[3], rd, rs);
			`CHK("l req", {16'h0, rows[i][15:0] & 16'h33FF}, rd)
		end
		// a write to a read-only word is answered and ignored
		bus_wr(view_idx[2], 32'hFFFFFFFF, rs);
		`CHK("ro resp", kr_train_pkg::RESP_OKAY, rs)
		bus_rd(view_idx[2], rd, rs);
		`CHK("ro kept", 32'h000000E4, rd)
		bus_rd(16'h9021, rd, rs);
		`CHK("unmapped", kr_train_pkg::RESP_SLVERR, rs)
		// start-up finishing raises a masked, then enabled, interrupt
		bus_wr(kr_train_pkg::IDX_IRQ_CLEAR, 32'h1F, rs);
		@(posedge clk_sys);
		startup_in_progress <= 1'b1;
		repeat (2) @(posedge clk_sys);
		startup_in_progress <= 1'b0;
		irq_is(1'b0);
		bus_rd(kr_train_pkg::IDX_IRQ_STATUS, rd, rs);
		`CHK("done event", 32'h1, rd)
		bus_wr(kr_train_pkg::IDX_IRQ_ENABLE, 32'h1, rs);
		irq_is(1'b1);
		bus_wr(kr_train_pkg::IDX_IRQ_CLEAR, 32'h1, rs);
		irq_is(1'b0);
		// partner declares its receiver ready, with its event enabled
		bus_wr(kr_train_pkg::IDX_IRQ_ENABLE, 32'h2, rs);
		@(posedge clk_sys);
		p_stat <= 16'h8000;
		p_load <= 1'b1;
		@(posedge clk_sys);
		p_load <= 1'b0;
		irq_is(1'b1);
		bus_rd(kr_train_pkg::IDX_IRQ_STATUS, rd, rs);
		`CHK("ready event", 32'h0A, rd)
		// reset in mid-run drops the interrupt, the enable and the partner status view
		@(posedge clk_sys);
		rst_n <= 1'b0;
		local_req <= '0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		irq_is(1'b0);
		bus_rd(kr_train_pkg::IDX_IRQ_ENABLE, rd, rs);
		`CHK("enable reset", 32'h0, rd)
		bus_rd(view_idx[2], rd, rs);
		`CHK("view reset", 32'h0, rd)
		tally_and_finish;
	end
endmodule
`default_nettype wire
